// ### verilog/tmr_pkg.sv
// Constants and carrier types for the timer flag, mask and divider block.
// Assumes a 25 MHz bus clock that also serves as the timer's E clock.
package tmr_pkg;
   // Register indices; the byte address on APB is four times the index.
   localparam logic [7:0] IDX_COUNT    = 8'h0E;
   localparam logic [7:0] IDX_CAP_BASE = 8'h10;
   localparam logic [7:0] IDX_CMP_BASE = 8'h13;
   localparam logic [7:0] IDX_SHARED   = 8'h17;
   localparam logic [7:0] IDX_EDGE     = 8'h21;
   localparam logic [7:0] IDX_MASK1    = 8'h22;
   localparam logic [7:0] IDX_FLAG1    = 8'h23;
   localparam logic [7:0] IDX_MASK2    = 8'h24;
   localparam logic [7:0] IDX_FLAG2    = 8'h25;
   localparam logic [7:0] IDX_ACCUMULATOR_CONTROL    = 8'h26;
   localparam logic [7:0] IDX_ACCUM    = 8'h27;

   // Field positions in the accumulator control register.
   localparam int B_ACC_EN   = 6;
   localparam int B_ACC_GATE = 5;
   localparam int B_ACC_EDGE = 4;
   localparam int B_SH_SEL   = 2;
   localparam logic [7:0] ACCUMULATOR_CONTROL_IMPL = 8'h77;

   // Reset values, and the last counter and accumulator values before wrap.
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_CMP  = 16'hFFFF;
   localparam logic [15:0] RST_CAP  = 16'h0000;
   localparam logic [15:0] CNT_LAST = 16'hFFFF;
   localparam logic [7:0]  ACC_LAST = 8'hFF;

   // Timing counts in bus clock cycles.
   localparam int PRESC_WINDOW    = 64;
   localparam int GATE_DIV_CYCLES = 64;
   localparam int RTI_BASE_LOG2   = 13;

   typedef struct packed {
      logic       accum;
      logic [3:0] capture;
   } tmr_pins_t;

   // Same bit order as {flag one, flag two [7:4]}.
   typedef struct packed {
      logic [3:0] compare;
      logic       shared;
      logic [2:0] capture;
      logic       wrap;
      logic       periodic;
      logic       accum_ovf;
      logic       accum_edge;
   } tmr_irq_t;
endpackage

// ### verilog/tmr_sync.sv
// Three-stage input synchroniser with qualified level and edge pulses.
// Assumes an asynchronous pin; a change counts once stages two and three
// agree.
`timescale 1ns/10ps
module tmr_sync (
   input  logic pclk,
   input  logic presetn,
   input  logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic [2:0] sh_reg;
   logic       lvl_reg;
   logic       rise_reg;
   logic       fall_reg;
   logic       lvl_next;

   assign lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg   <= 3'h0;
         lvl_reg  <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         sh_reg   <= {sh_reg[1:0], pin};
         lvl_reg  <= lvl_next;
         rise_reg <= lvl_next & ~lvl_reg;
         fall_reg <= ~lvl_next & lvl_reg;
      end
   end

   assign level = lvl_reg;
   assign rise  = rise_reg;
   assign fall  = fall_reg;
endmodule

// ### verilog/tmr_core.sv
// Timer flags, masks, prescaler, periodic divider and pulse accumulator.
// Assumes an APB master on pclk and asynchronous capture and accumulator
// pins; special_mode is a static level from the chip's mode logic.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Compare flag with its enable set raises that compare request.
// - Capture flag with its enable set raises that capture request.
// - Shared enable gates capture four or compare five as selected.
// - Writing one to a flag bit clears only that flag.
// - Compare flag sets when the counter equals the compare value.
// - Shared flag sets from capture four or compare five per select.
// - Capture flag sets on the selected edge of its pin.
// - Mask two upper bits enable flag two upper bits one-to-one.
// - Periodic enable with periodic flag set requests an interrupt.
// - Overflow flag sets when the counter wraps from all ones.
// - Prescaler field writable once, within 64 cycles, normal modes.
// - Unimplemented register bits always read as zero.
// - Select zero makes the shared channel compare five, one capture.
// - Periodic base is bus clock over two to the 13, not prescaled.
// - Rate field gives periods of two to the 13 through 16 cycles.
// - Rate field resets to fastest and may be rewritten any time.
// - Eight-bit accumulator, readable and writable, event or gated.
// - Gated mode counts E over 64 while pin gates; event uses edges.
// - Shared register writes are ignored while it is capture four.
// - Edge field: 00 off, 01 rising, 10 falling, 11 any edge.
module tmr_core
   import tmr_pkg::*;
#(
   parameter int RTI_LOG2 = RTI_BASE_LOG2
) (
   input  logic        pclk,
   input  logic        presetn,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [11:0] paddr,
   input  logic [31:0] pwdata,
   input  logic [3:0]  pstrb,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   input  logic        special_mode,
   input  tmr_pins_t   pins,
   output tmr_irq_t    irq
);
   localparam int RTI_W = RTI_LOG2 + 3;

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       r,
                                     input logic       f);
      return (sel[0] & r) | (sel[1] & f);
   endfunction

   function automatic logic [3:0] presc_last(input logic [1:0] sel);
      case (sel)
         2'b00:   return 4'h0;
         2'b01:   return 4'h3;
         2'b10:   return 4'h7;
         default: return 4'hF;
      endcase
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [3:0]  be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   logic [15:0]      count_reg;
   logic [15:0]      cap_reg [3];
   logic [15:0]      cmp_reg [4];
   logic [15:0]      shared_reg;
   logic [7:0]       edge_reg;
   logic [7:0]       mask1_reg;
   logic [7:0]       flag1_reg;
   logic [3:0]       mask2_reg;
   logic [1:0]       presc_reg;
   logic [3:0]       flag2_reg;
   logic [7:0]       accumulator_control_reg;
   logic [7:0]       accum_reg;
   logic [3:0]       pre_cnt_reg;
   logic [6:0]       age_reg;
   logic             presc_done_reg;
   logic [RTI_W-1:0] rti_div_reg;
   logic [5:0]       gdiv_reg;
   logic [31:0]      prdata_reg;
   tmr_irq_t         irq_reg;

   logic [4:0]       s_lvl;
   logic [4:0]       s_rise;
   logic [4:0]       s_fall;
   logic [3:0]       cap_hit;
   logic [3:0]       cmp_evt;
   logic [3:0]       w_cmp;
   logic [7:0]       set1;
   logic [3:0]       set2;
   logic [31:0]      rd_word;
   logic             mapped;
   logic [RTI_W-1:0] rti_mask;

   wire [4:0] pin_vec = {pins.accum, pins.capture};
   wire [7:0] idx     = paddr[9:2];
   wire       addr_ok = (paddr[11:10] == 2'b00);
   wire       wr_ok   = psel & penable & pwrite & addr_ok;
   wire       w_b0    = wr_ok & pstrb[0];
   wire       w_mask1 = w_b0 & (idx == IDX_MASK1);
   wire       w_flag1 = w_b0 & (idx == IDX_FLAG1);
   wire       w_mask2 = w_b0 & (idx == IDX_MASK2);
   wire       w_flag2 = w_b0 & (idx == IDX_FLAG2);
   wire       w_accumulator_control = w_b0 & (idx == IDX_ACCUMULATOR_CONTROL);
   wire       w_edge  = w_b0 & (idx == IDX_EDGE);
   wire       w_accum = w_b0 & (idx == IDX_ACCUM);
   wire       w_share = wr_ok & (idx == IDX_SHARED);

   wire       acc_en   = accumulator_control_reg[B_ACC_EN];
   wire       acc_gate = accumulator_control_reg[B_ACC_GATE];
   wire       acc_edge = accumulator_control_reg[B_ACC_EDGE];
   wire       sh_sel   = accumulator_control_reg[B_SH_SEL];
   wire [1:0] rtr      = accumulator_control_reg[1:0];

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_sync
         tmr_sync u_sync (
            .pclk    (pclk),
            .presetn (presetn),
            .pin     (pin_vec[g]),
            .level   (s_lvl[g]),
            .rise    (s_rise[g]),
            .fall    (s_fall[g])
         );
      end
      for (g = 0; g < 4; g++) begin : g_cap
         assign cap_hit[g] = edge_hit(edge_reg[2*g+1 -: 2], s_rise[g],
                                      s_fall[g]);
      end
   endgenerate

   // Counter prescaler; outside special mode the field can only be written early after reset.
   wire        cnt_tick   = (pre_cnt_reg == presc_last(presc_reg));
   wire [15:0] count_inc  = count_reg + 16'h0001;
   wire        wrap_evt   = cnt_tick & (count_reg == CNT_LAST);
   wire        age_full   = (age_reg == 7'(PRESC_WINDOW));
   wire        presc_open = special_mode | (~presc_done_reg & ~age_full);

   // Compare matches fire on the tick that brings the counter to the value.
   generate
      for (g = 0; g < 4; g++) begin : g_cmp
         assign w_cmp[g]   = wr_ok & (idx == IDX_CMP_BASE + 8'(3 - g));
         assign cmp_evt[g] = cnt_tick & (count_inc == cmp_reg[g]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cmp_reg[g] <= RST_CMP;
            end else if (w_cmp[g]) begin
               cmp_reg[g] <= merge16(cmp_reg[g], pwdata[15:0], pstrb);
            end
         end
      end
      for (g = 0; g < 3; g++) begin : g_capr
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cap_reg[g] <= RST_CAP;
            end else if (cap_hit[g]) begin
               cap_reg[g] <= count_reg;
            end
         end
      end
   endgenerate

   // The shared channel works as capture four when selected, else compare.
   wire sh_cap_evt = sh_sel & cap_hit[3];
   wire sh_cmp_evt = ~sh_sel & cnt_tick & (count_inc == shared_reg);
   wire sh_write   = w_share & ~sh_sel;

   // Periodic divider runs straight off the bus clock.
   assign rti_mask = RTI_W'((64'd1 << (RTI_LOG2 + int'(rtr))) - 64'd1);
   wire rti_tick = ((rti_div_reg & rti_mask) == rti_mask);

   // Pulse accumulator: the active edge both counts and flags in event
   // mode, and marks the end of a gate in gated mode.
   wire gdiv_tick = (gdiv_reg == 6'(GATE_DIV_CYCLES - 1));
   wire a_edge    = acc_edge ? s_rise[4] : s_fall[4];
   wire gate_on   = s_lvl[4] ^ acc_edge;
   wire acc_inc   = acc_en & (acc_gate ? (gate_on & gdiv_tick)
                                       : a_edge);
   wire aovf_evt  = acc_inc & ~w_accum & (accum_reg == ACC_LAST);
   wire aedge_evt = acc_en & a_edge;

   assign set1 = {cmp_evt, sh_cap_evt | sh_cmp_evt, cap_hit[2:0]};
   assign set2 = {wrap_evt, rti_tick, aovf_evt, aedge_evt};
   wire [7:0] clr1 = w_flag1 ? pwdata[7:0] : RST_BYTE;
   wire [3:0] clr2 = w_flag2 ? pwdata[7:4] : 4'h0;
   wire [7:0] flag1_next = (flag1_reg & ~clr1) | set1;
   wire [3:0] flag2_next = (flag2_reg & ~clr2) | set2;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg      <= RST_CAP;
         pre_cnt_reg    <= 4'h0;
         age_reg        <= 7'h00;
         presc_done_reg <= 1'b0;
         presc_reg      <= 2'b00;
         rti_div_reg    <= '0;
         gdiv_reg       <= 6'h00;
      end else begin
         count_reg   <= cnt_tick ? count_inc : count_reg;
         pre_cnt_reg <= cnt_tick ? 4'h0 : pre_cnt_reg + 4'h1;
         age_reg     <= age_full ? age_reg : age_reg + 7'h01;
         rti_div_reg <= rti_div_reg + RTI_W'(1);
         gdiv_reg    <= gdiv_reg + 6'h01;
         if (w_mask2 && presc_open) begin
            presc_reg      <= pwdata[1:0];
            presc_done_reg <= ~special_mode;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask1_reg  <= RST_BYTE;
         mask2_reg  <= 4'h0;
         flag1_reg  <= RST_BYTE;
         flag2_reg  <= 4'h0;
         edge_reg   <= RST_BYTE;
         accumulator_control_reg  <= RST_BYTE;
         accum_reg  <= RST_BYTE;
         shared_reg <= RST_CMP;
      end else begin
         flag1_reg <= flag1_next;
         flag2_reg <= flag2_next;
         if (w_mask1) mask1_reg <= pwdata[7:0];
         if (w_mask2) mask2_reg <= pwdata[7:4];
         if (w_edge) edge_reg <= pwdata[7:0];
         if (w_accumulator_control) accumulator_control_reg <= pwdata[7:0] & ACCUMULATOR_CONTROL_IMPL;
         if (w_accum) begin
            accum_reg <= pwdata[7:0];
         end else if (acc_inc) begin
            accum_reg <= accum_reg + 8'h01;
         end
         if (sh_cap_evt) begin
            shared_reg <= count_reg;
         end else if (sh_write) begin
            shared_reg <= merge16(shared_reg, pwdata[15:0], pstrb);
         end
      end
   end

   // Read data is latched in the setup phase and shown in the access phase.
   always_comb begin
      mapped  = 1'b1;
      rd_word = 32'h0000_0000;
      case (idx)
         IDX_COUNT:           rd_word = 32'(count_reg);
         IDX_CAP_BASE:        rd_word = 32'(cap_reg[2]);
         IDX_CAP_BASE + 8'd1: rd_word = 32'(cap_reg[1]);
         IDX_CAP_BASE + 8'd2: rd_word = 32'(cap_reg[0]);
         IDX_CMP_BASE:        rd_word = 32'(cmp_reg[3]);
         IDX_CMP_BASE + 8'd1: rd_word = 32'(cmp_reg[2]);
         IDX_CMP_BASE + 8'd2: rd_word = 32'(cmp_reg[1]);
         IDX_CMP_BASE + 8'd3: rd_word = 32'(cmp_reg[0]);
         IDX_SHARED:          rd_word = 32'(shared_reg);
         IDX_EDGE:            rd_word = 32'(edge_reg);
         IDX_MASK1:           rd_word = 32'(mask1_reg);
         IDX_FLAG1:           rd_word = 32'(flag1_reg);
         IDX_MASK2:           rd_word = 32'({mask2_reg, 2'b00,
                                             presc_reg});
         IDX_FLAG2:           rd_word = 32'({flag2_reg, 4'h0});
         IDX_ACCUMULATOR_CONTROL:           rd_word = 32'(accumulator_control_reg & ACCUMULATOR_CONTROL_IMPL);
         IDX_ACCUM:           rd_word = 32'(accum_reg);
         default:             mapped  = 1'b0;
      endcase
   end

   wire rd_setup = psel & ~penable & ~pwrite;
   wire hit      = mapped & addr_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         irq_reg    <= '0;
      end else begin
         if (rd_setup) prdata_reg <= hit ? rd_word : 32'h0000_0000;
         irq_reg <= {flag1_reg & mask1_reg,
                     flag2_reg & mask2_reg};
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign irq     = irq_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_cmp_irq_gate: assert property (
      irq.compare[3] == $past(flag1_reg[7] & mask1_reg[7]))
      else $error("Compare one request does not follow flag and enable.");
   a_cap_irq_gate: assert property (
      (flag1_reg[2] && mask1_reg[2]) |=> irq.capture[2])
      else $error("Capture one request missing.");
   a_shared_irq: assert property (
      (flag1_reg[3] && !mask1_reg[3]) |=> !irq.shared)
      else $error("Shared request raised while disabled.");
   a_w1c_clear: assert property (
      (w_flag1 && pwdata[0] && !set1[0]) |=> !flag1_reg[0])
      else $error("Flag one bit zero not cleared by write of one.");
   a_set_wins: assert property (
      (w_flag1 && pwdata[4] && set1[4]) |=> flag1_reg[4])
      else $error("Set lost against a same-cycle clear.");
   a_rti_set_wins: assert property (
      (w_flag2 && pwdata[6] && rti_tick) |=> flag2_reg[2])
      else $error("Periodic set lost against a same-cycle clear.");
   a_zero_keeps: assert property (
      (w_flag2 && !pwdata[7] && flag2_reg[3]) |=> flag2_reg[3])
      else $error("Overflow flag cleared by a zero write.");
   a_cmp_match: assert property (
      (cnt_tick && count_inc == cmp_reg[3]) |=> flag1_reg[7])
      else $error("Compare one match did not set its flag.");
   a_wrap_flag: assert property (
      (cnt_tick && count_reg == CNT_LAST) |=>
         flag2_reg[3] && count_reg == 16'h0000)
      else $error("Counter wrap did not set the overflow flag.");
   a_cap_latch: assert property (
      cap_hit[2] |=> flag1_reg[2] && cap_reg[2] == $past(count_reg))
      else $error("Capture one did not latch the counter.");
   a_shared_ro: assert property (
      (w_share && sh_sel && !cap_hit[3]) |=> $stable(shared_reg))
      else $error("Shared register written while capturing.");
   a_presc_lock: assert property (
      (!special_mode && (age_full || presc_done_reg)) |=>
         $stable(presc_reg))
      else $error("Prescaler changed after its write window closed.");
   a_rti_flag: assert property (
      (rti_tick && rtr == 2'b00) |=> flag2_reg[2] ##1 !rti_tick)
      else $error("Periodic tick did not set the periodic flag.");
   a_flag2_zero: assert property (
      (rd_setup && addr_ok && idx == IDX_FLAG2) |=>
         prdata[3:0] == 4'h0)
      else $error("Unimplemented flag two bits read as nonzero.");
   a_acc_wrap: assert property (
      (acc_inc && !w_accum && accum_reg == ACC_LAST) |=>
         accum_reg == 8'h00 && flag2_reg[1])
      else $error("Accumulator wrap did not set its overflow flag.");
endmodule

// ### tb/tmr_core_test.sv
// Self-checking bench for the timer flag, mask and divider block.
// Assumes tmr_pkg and tmr_core are compiled first; APB slave, no wait states.
`timescale 1ns/10ps
module tmr_core_test;
   import tmr_pkg::*;
   localparam int RL    = 4;
   localparam int LIMIT = 90000;
   typedef struct packed {
      logic [31:0] data;
      logic [31:0] dmask;
      logic        err;
      logic [11:0] irq;
      logic [11:0] imask;
   } tmr_note_t;

   logic        pclk         = 1'b0;
   logic        presetn      = 1'b0;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [11:0] paddr        = 12'h000;
   logic [31:0] pwdata       = 32'h0000_0000;
   logic [3:0]  pstrb        = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        special_mode = 1'b0;
   tmr_pins_t   pins         = '0;
   tmr_irq_t    irq;
   tmr_note_t   notes[$];
   tmr_note_t   cur;
   int          n_errors     = 0;
   int          checks       = 0;
   int          cycles       = 0;
   int          t0;
   logic [31:0] rd;
   logic [31:0] rnd;
   logic [15:0] cv;

   always #20 pclk = ~pclk;

   tmr_core #(.RTI_LOG2(RL)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .special_mode(special_mode), .pins(pins), .irq(irq));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Reads are judged at the access edge against the oldest note.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && notes.size() > 0) begin
         cur = notes.pop_front();
         chk(prdata & cur.dmask, cur.data & cur.dmask);
         chk({31'h0, pslverr}, {31'h0, cur.err});
         chk({20'h0, irq & cur.imask},
             {20'h0, cur.irq & cur.imask});
      end
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_errors++;
         complete_run();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      pstrb   <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rdx(input logic [7:0] idx, input logic [31:0] exp,
                      input logic [31:0] dm, input logic err,
                      input logic [11:0] ei, input logic [11:0] im);
      notes.push_back({exp, dm, err, ei, im});
      apb(1'b0, idx, 32'h0000_0000);
   endtask

   task automatic rdb(input logic [7:0] idx, input logic [7:0] exp);
      rdx(idx, {24'h0, exp}, 32'hFFFF_FFFF, 1'b0, 12'h000, 12'h000);
   endtask

   task automatic rdi(input logic [7:0] idx, input logic [7:0] exp,
                      input logic [7:0] dm, input logic [11:0] ei,
                      input logic [11:0] im);
      rdx(idx, {24'h0, exp}, {24'h0, dm}, 1'b0, ei, im);
   endtask

   // Waits until the given request bit is high, bounded.
   task automatic wait_irq(input int b, input int lim);
      int n;
      n = 0;
      while (irq[b] !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask

   initial begin
      rnd = $urandom(32'h0000_774C);
      cyc(20);
      presetn <= 1'b1;
      rdi(IDX_FLAG2, 8'h00, 8'hFF, 12'h000, 12'hFFF);
      rdb(IDX_FLAG1, 8'h00);
      rdb(IDX_MASK1, 8'h00);
      rdb(IDX_MASK2, 8'h00);
      rdb(IDX_ACCUMULATOR_CONTROL, 8'h00);
      wr(IDX_MASK2, 32'h0000_00FD);
      rdb(IDX_MASK2, 8'hF1);
      cyc(70);
      wr(IDX_MASK2, 32'h0000_00F2);
      rdb(IDX_MASK2, 8'hF1);
      special_mode <= 1'b1;
      wr(IDX_MASK2, 32'h0000_00F0);
      rdb(IDX_MASK2, 8'hF0);
      special_mode <= 1'b0;
      rdx(8'h30, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1,
          12'h000, 12'h000);
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_00FF);
      rdb(IDX_ACCUMULATOR_CONTROL, ACCUMULATOR_CONTROL_IMPL);
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_0000);
      wr(IDX_FLAG2, 32'h0000_00FF);
      rdi(IDX_FLAG2, 8'h00, 8'h0F, 12'h000, 12'h000);
      rnd = $urandom;
      wr(IDX_MASK1, rnd);
      rdb(IDX_MASK1, rnd[7:0]);
      wr(IDX_MASK1, 32'h0000_00FF);
      wr(IDX_FLAG1, 32'h0000_00FF);
      apb(1'b0, IDX_COUNT, 32'h0000_0000);
      cv = rd[15:0] + 16'h0028 + 16'($urandom_range(15, 0));
      wr(IDX_CMP_BASE, {16'h0, cv});
      cyc(70);
      rdi(IDX_FLAG1, 8'h80, 8'h80, 12'h800, 12'h800);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_EDGE, {24'h0, 2'b00, m[1:0], 4'h0});
         wr(IDX_FLAG1, 32'h0000_0004);
         pins.capture[2] <= 1'b1;
         cyc(8);
         rdi(IDX_FLAG1, m[0] ? 8'h04 : 8'h00, 8'h04,
             m[0] ? 12'h040 : 12'h000, 12'h040);
         wr(IDX_FLAG1, 32'h0000_0004);
         pins.capture[2] <= 1'b0;
         cyc(8);
         rdi(IDX_FLAG1, m[1] ? 8'h04 : 8'h00, 8'h04,
             m[1] ? 12'h040 : 12'h000, 12'h040);
      end
      wr(IDX_FLAG1, 32'h0000_0004);
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_0004);
      wr(IDX_EDGE, 32'h0000_00C0);
      wr(IDX_SHARED, 32'h0000_1234);
      rdx(IDX_SHARED, 32'h0000_FFFF, 32'h0000_FFFF, 1'b0,
          12'h000, 12'h000);
      wr(IDX_FLAG1, 32'h0000_0008);
      pins.capture[3] <= 1'b1;
      cyc(8);
      rdi(IDX_FLAG1, 8'h08, 8'h08, 12'h080, 12'h080);
      wr(IDX_FLAG1, 32'h0000_0008);
      wr(IDX_MASK1, 32'h0000_00F7);
      pins.capture[3] <= 1'b0;
      cyc(8);
      rdi(IDX_FLAG1, 8'h08, 8'h08, 12'h000, 12'h080);
      wr(IDX_FLAG1, 32'h0000_0008);
      wr(IDX_MASK1, 32'h0000_00FF);
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_0000);
      pins.capture[3] <= 1'b1;
      cyc(8);
      rdi(IDX_FLAG1, 8'h00, 8'h08, 12'h000, 12'h080);
      wr(IDX_SHARED, 32'h0000_1234);
      rdx(IDX_SHARED, 32'h0000_1234, 32'h0000_FFFF, 1'b0,
          12'h000, 12'h000);
      for (int r = 0; r < 4; r++) begin
         wr(IDX_ACCUMULATOR_CONTROL, r);
         wr(IDX_FLAG2, 32'h0000_0040);
         cyc(2);
         wait_irq(2, 300);
         t0 = cycles;
         wr(IDX_FLAG2, 32'h0000_0040);
         cyc(2);
         wait_irq(2, 300);
         chk(cycles - t0, 2 ** (RL + r));
         // Lands the clearing write on the next tick; the set must win.
         cyc(2 ** (RL + r) - 5);
         wr(IDX_FLAG2, 32'h0000_0040);
         rdi(IDX_FLAG2, 8'h40, 8'h40, 12'h004, 12'h004);
      end
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_0000);
      pins.accum <= 1'b1;
      cyc(6);
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_0040);
      wr(IDX_ACCUM, 32'h0000_00FE);
      wr(IDX_FLAG2, 32'h0000_0030);
      pins.accum <= 1'b0;
      cyc(6);
      pins.accum <= 1'b1;
      cyc(6);
      pins.accum <= 1'b0;
      cyc(6);
      rdb(IDX_ACCUM, 8'h00);
      rdi(IDX_FLAG2, 8'h30, 8'h30, 12'h003, 12'h003);
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_0060);
      wr(IDX_ACCUM, 32'h0000_0000);
      pins.accum <= 1'b1;
      cyc(GATE_DIV_CYCLES * 4);
      pins.accum <= 1'b0;
      cyc(8);
      rdb(IDX_ACCUM, 8'h04);
      wr(IDX_ACCUMULATOR_CONTROL, 32'h0000_0000);
      wr(IDX_EDGE, 32'h0000_0000);
      wr(IDX_FLAG1, 32'h0000_00FF);
      wr(IDX_FLAG2, 32'h0000_00F0);
      wait_irq(3, 70000);
      cyc(2);
      rdi(IDX_FLAG2, 8'h80, 8'h80, 12'h008, 12'h008);
      wr(IDX_FLAG2, 32'h0000_0070);
      rdi(IDX_FLAG2, 8'h80, 8'h80, 12'h008, 12'h008);
      rdb(IDX_FLAG1, 8'h78);
      wr(IDX_FLAG1, 32'h0000_0040);
      rdb(IDX_FLAG1, 8'h38);
      wr(IDX_FLAG1, 32'h0000_0000);
      rdb(IDX_FLAG1, 8'h38);
      cyc(4);
      complete_run();
   end
endmodule
